// File: hw/adcseq_pkg.sv
// Shared constants and types for the converter sequencer
package adcseq_pkg;
   // ==========================================================
   // Register offsets
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_RESULT = 4'h1;
   localparam logic [3:0] REG_ANCFG = 4'h2;
   localparam logic [3:0] REG_PORT = 4'h3;
   localparam logic [3:0] REG_FLAGS = 4'h4;
   // ==========================================================
   // Register fields and reset values
   localparam int CTRL_CLKSEL_LSB = 6;
   localparam int CTRL_CHAN_LSB = 3;
   localparam int CTRL_GO_BIT = 2;
   localparam int CTRL_ON_BIT = 0;
   localparam int FLAGS_DONE_BIT = 0;
   localparam int FLAGS_IRQEN_BIT = 1;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [2:0] ANCFG_RESET = 3'h0;
   // ==========================================================
   // Clock select codes and the compare trigger mode
   localparam logic [1:0] CLK_DIV2 = 2'h0;
   localparam logic [1:0] CLK_DIV8 = 2'h1;
   localparam logic [1:0] CLK_DIV32 = 2'h2;
   localparam logic [1:0] CLK_RC = 2'h3;
   localparam logic [3:0] CMP_MODE_TRIGGER = 4'hB;
   // ==========================================================
   // Timing: prescaler limits in clocks, phase lengths in half bit periods, instruction cycle in ns
   localparam logic [4:0] HALF_DIV2 = 5'h00;
   localparam logic [4:0] HALF_DIV8 = 5'h03;
   localparam logic [4:0] HALF_DIV32 = 5'h0F;
   localparam logic [4:0] CONV_HALVES = 5'h13;
   localparam logic [4:0] RECOV_HALVES = 5'h04;
   localparam logic [4:0] FIRST_BIT_HALF = 5'h02;
   localparam int INSTR_CYCLE_NS = 400;
   localparam int CLK_PERIOD_NS = 100;
   localparam logic [2:0] INSTR_CYCLES = 3'((INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   // ==========================================================
   // Types
   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_ACQ = 5'b00010,
      ST_DELAY = 5'b00100,
      ST_CONV = 5'b01000,
      ST_RECOV = 5'b10000
   } adcseq_state_t;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } adcseq_bus_t;

   typedef struct packed {
      logic sample;
      logic power;
      logic [2:0] channel;
      logic [7:0] trial;
   } adcseq_analog_t;
endpackage : adcseq_pkg

// File: hw/adcseq_top.sv
// Successive-approximation converter sequencer with register port
//
// Our own choices: the address map and the strobed register port.
`timescale 1ns/1ps

// Notes on behaviour
// - After completion the hold capacitor stays off the input for two bit periods.
// - A full conversion lasts nine and a half bit periods.
// - Clock select 00/01/10 give 2/8/32 oscillator periods; 11 picks the RC clock.
// - Port reads return zero on every pin set up as analog.
// - The selected channel is converted whatever its direction or digital setting.
// - Clearing go mid-conversion aborts it; the result register keeps its contents.
// - After an abort wait two bit periods, then acquire the selected channel.
// - Normal completion clears go and loads the eight-bit result.
// - Acquisition does not depend on the resolution the user keeps.
// - Bits converted after switching to a too-short period may be wrong.
// - With the RC clock, conversion starts one instruction cycle after go.
// - RC conversion done in sleep wakes if enabled, else powers down, on bit kept.
// - Sleep on an oscillator clock aborts and powers down, on bit kept.
// - Setting go while the converter is on and acquiring starts a conversion.
// - Completion also sets the done flag.
// - Reset turns the converter off and aborts; the result is not reset.
// - Compare trigger in mode 1011 sets go only while the converter is on.
module adcseq_top
   import adcseq_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Register port
   input wire adcseq_bus_t i_bus,
   output logic [7:0] o_rdata,
   // Core and neighbouring units
   input wire logic i_sleep,
   input wire logic i_special_trigger,
   input wire logic [3:0] i_compare_mode_field,
   output logic o_wake,
   output logic o_conversion_done_flag,
   // Analog side
   input wire logic i_rc_conversion_clock,
   input wire logic i_comp_above,
   input wire logic [4:0] i_pin_level,
   output adcseq_analog_t o_analog
);

   // ==========================================================
   // Functions
   function automatic logic [4:0] half_limit(input logic [1:0] sel);
      logic [4:0] lim;
      lim = HALF_DIV2;
      if (sel == CLK_DIV8) begin
         lim = HALF_DIV8;
      end else if (sel == CLK_DIV32) begin
         lim = HALF_DIV32;
      end
      return lim;
   endfunction : half_limit

   // Pins ordered as channels 0..4; a set bit marks an analog pin
   function automatic logic [4:0] analog_mask(input logic [2:0] cfg);
      logic [4:0] m;
      m = 5'h1F;
      if (cfg == 3'h1 || cfg == 3'h3) begin
         m = 5'h17;
      end else if (cfg == 3'h4) begin
         m = 5'h0B;
      end else if (cfg == 3'h7) begin
         m = 5'h00;
      end
      return m;
   endfunction : analog_mask

   // ==========================================================
   // Registers and state
   logic [1:0] conv_clock_select;
   logic [2:0] input_channel_select;
   logic go;
   logic converter_on;
   logic [7:0] conversion_result;
   logic [2:0] port_analog_config;
   logic conversion_done_flag;
   logic conversion_irq_enable;
   logic powered_down;
   adcseq_state_t state;
   logic [4:0] presc;
   logic [4:0] halves;
   logic [2:0] delay_cnt;
   logic [7:0] sar;
   logic [7:0] trial;
   logic [2:0] bitpos;
   logic [1:0] rc_sync;
   logic rc_last;
   logic [1:0] cmp_sync;
   logic [9:0] pin_sync;
   logic rc_sel;
   logic half_tick;
   logic ctrl_wr;
   logic go_set_sw;
   logic go_clr_sw;
   logic trigger_ok;
   logic finish;
   logic abort;
   logic sleep_abort;

   assign rc_sel = (conv_clock_select == CLK_RC);
   assign ctrl_wr = i_bus.wr && (i_bus.addr == REG_CTRL);
   // Go only takes hold on a converter that was already on
   assign go_set_sw = ctrl_wr && i_bus.wdata[CTRL_GO_BIT] && converter_on;
   assign go_clr_sw = ctrl_wr && !i_bus.wdata[CTRL_GO_BIT];
   assign trigger_ok = i_special_trigger && converter_on
                       && (i_compare_mode_field == CMP_MODE_TRIGGER);
   assign finish = (state == ST_CONV) && half_tick && (halves == CONV_HALVES - 5'h01);
   assign sleep_abort = i_sleep && !rc_sel && (state == ST_CONV || state == ST_DELAY);
   assign abort = ((state == ST_CONV || state == ST_DELAY) && go_clr_sw) || sleep_abort;

   // ==========================================================
   // Synchronisers for the RC clock, comparator and pins
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         rc_sync <= 2'h0;
         rc_last <= 1'b0;
         cmp_sync <= 2'h0;
         pin_sync <= 10'h000;
      end else begin
         rc_sync <= {rc_sync[0], i_rc_conversion_clock};
         rc_last <= rc_sync[1];
         cmp_sync <= {cmp_sync[0], i_comp_above};
         pin_sync <= {pin_sync[4:0], i_pin_level};
      end
   end

   // ==========================================================
   // Half bit period strobe
   // Each RC edge is half a period, so both edges count
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         presc <= 5'h00;
      end else if (state == ST_ACQ || state == ST_IDLE || half_tick || abort) begin
         presc <= 5'h00;
      end else begin
         presc <= presc + 5'h01;
      end
   end

   always_comb begin
      if (rc_sel) begin
         half_tick = (rc_sync[1] != rc_last);
      end else begin
         half_tick = (presc >= half_limit(conv_clock_select));
      end
   end

   // ==========================================================
   // Sequencer
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state <= ST_IDLE;
         halves <= 5'h00;
         delay_cnt <= 3'h0;
      end else if (!converter_on) begin
         state <= ST_IDLE;
      end else begin
         case (state)
            ST_IDLE: begin
               state <= ST_ACQ;
            end
            ST_ACQ: begin
               halves <= 5'h00;
               delay_cnt <= 3'h0;
               // Acquisition length is fixed only by when go is written or the compare trigger fires
               if (go_set_sw || trigger_ok) begin
                  state <= rc_sel ? ST_DELAY : ST_CONV;
               end
            end
            ST_DELAY: begin
               delay_cnt <= delay_cnt + 3'h1;
               if (abort) begin
                  state <= ST_RECOV;
               end else if (delay_cnt == INSTR_CYCLES - 3'h1) begin
                  state <= ST_CONV;
               end
            end
            ST_CONV: begin
               if (abort) begin
                  halves <= 5'h00;
                  state <= ST_RECOV;
               end else if (finish) begin
                  halves <= 5'h00;
                  state <= ST_RECOV;
               end else if (half_tick) begin
                  halves <= halves + 5'h01;
               end
            end
            ST_RECOV: begin
               if (half_tick) begin
                  halves <= halves + 5'h01;
                  if (halves == RECOV_HALVES - 5'h01) begin
                     state <= ST_ACQ;
                  end
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // Successive approximation: a bit is decided every full period
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         sar <= 8'h00;
         trial <= 8'h00;
         bitpos <= 3'h7;
      end else if (state != ST_CONV) begin
         sar <= 8'h00;
         trial <= 8'h80;
         bitpos <= 3'h7;
      end else if (half_tick && halves >= FIRST_BIT_HALF && !halves[0]) begin
         // Too-short periods here leave later bits unreliable
         sar[bitpos] <= cmp_sync[1];
         if (bitpos != 3'h0) begin
            trial[bitpos] <= cmp_sync[1];
            trial[bitpos - 3'h1] <= 1'b1;
            bitpos <= bitpos - 3'h1;
         end
      end
   end

   // ==========================================================
   // Control register
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         conv_clock_select <= CTRL_RESET[CTRL_CLKSEL_LSB +: 2];
         input_channel_select <= CTRL_RESET[CTRL_CHAN_LSB +: 3];
         converter_on <= CTRL_RESET[CTRL_ON_BIT];
      end else if (ctrl_wr) begin
         conv_clock_select <= i_bus.wdata[CTRL_CLKSEL_LSB +: 2];
         input_channel_select <= i_bus.wdata[CTRL_CHAN_LSB +: 3];
         converter_on <= i_bus.wdata[CTRL_ON_BIT];
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         go <= 1'b0;
      end else if (finish || sleep_abort || !converter_on) begin
         go <= 1'b0;
      end else if (go_set_sw || trigger_ok) begin
         go <= 1'b1;
      end else if (go_clr_sw) begin
         go <= 1'b0;
      end
   end

   // ==========================================================
   // Result, analog configuration, flags
   // Result has no reset so its prior value survives a reset
   always_ff @(posedge i_clk) begin
      if (finish) begin
         conversion_result <= {sar[7:1], cmp_sync[1]};
      end else if (i_bus.wr && i_bus.addr == REG_RESULT) begin
         conversion_result <= i_bus.wdata;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         port_analog_config <= ANCFG_RESET;
      end else if (i_bus.wr && i_bus.addr == REG_ANCFG) begin
         port_analog_config <= i_bus.wdata[2:0];
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         conversion_done_flag <= 1'b0;
         conversion_irq_enable <= 1'b0;
      end else begin
         if (finish) begin
            conversion_done_flag <= 1'b1;
         end else if (i_bus.wr && i_bus.addr == REG_FLAGS) begin
            conversion_done_flag <= i_bus.wdata[FLAGS_DONE_BIT];
         end
         if (i_bus.wr && i_bus.addr == REG_FLAGS) begin
            conversion_irq_enable <= i_bus.wdata[FLAGS_IRQEN_BIT];
         end
      end
   end

   // ==========================================================
   // Sleep handling
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         powered_down <= 1'b0;
         o_wake <= 1'b0;
      end else begin
         o_wake <= finish && i_sleep && rc_sel && conversion_irq_enable;
         if (!i_sleep) begin
            powered_down <= 1'b0;
         end else if (sleep_abort) begin
            powered_down <= 1'b1;
         end else if (finish && rc_sel && !conversion_irq_enable) begin
            powered_down <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Read port and analog outputs
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rdata <= 8'h00;
      end else if (!i_bus.rd) begin
         o_rdata <= 8'h00;
      end else if (i_bus.addr == REG_CTRL) begin
         o_rdata <= {conv_clock_select, input_channel_select, go, 1'b0, converter_on};
      end else if (i_bus.addr == REG_RESULT) begin
         o_rdata <= conversion_result;
      end else if (i_bus.addr == REG_ANCFG) begin
         o_rdata <= {5'h00, port_analog_config};
      end else if (i_bus.addr == REG_PORT) begin
         o_rdata <= {3'h0, pin_sync[9:5] & ~analog_mask(port_analog_config)};
      end else if (i_bus.addr == REG_FLAGS) begin
         o_rdata <= {6'h00, conversion_irq_enable, conversion_done_flag};
      end else begin
         o_rdata <= 8'h00;
      end
   end

   // Channel mux ignores pin direction and analog setting
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_analog <= '0;
      end else begin
         o_analog.channel <= input_channel_select;
         o_analog.sample <= (state == ST_ACQ || state == ST_DELAY)
                            && converter_on && !powered_down;
         o_analog.power <= converter_on && !powered_down;
         o_analog.trial <= trial;
      end
   end

   assign o_conversion_done_flag = conversion_done_flag;

endmodule : adcseq_top

// File: tb/adcseq_pins.sv
// Behavioural analog pins and comparator behind the channel mux
`timescale 1ns/1ps
module adcseq_pins
   import adcseq_pkg::*;
(
   // Clock
   input wire logic i_clk,
   // Converter side
   input wire adcseq_analog_t i_analog,
   input wire logic [7:0] i_level [5],
   // Toward the design
   output logic o_comp_above,
   output logic [4:0] o_pin_level
);
   logic last_comp = 1'b0;
   // ==========================================================
   // Comparator
   // An unpowered comparator gives no usable answer, so it toggles
   always_ff @(posedge i_clk) begin
      last_comp <= o_comp_above;
   end
   always_comb begin
      if (i_analog.power && i_analog.channel < 3'h5) begin
         o_comp_above = i_level[i_analog.channel] >= i_analog.trial;
      end else begin
         o_comp_above = ~last_comp;
      end
   end
   // ==========================================================
   // Digital input buffers see the level whatever the pin setting
   assign o_pin_level = {i_level[4][7], i_level[3][7], i_level[2][7],
      i_level[1][7], i_level[0][7]};
endmodule : adcseq_pins

// File: tb/adcseq_top_chk.sv
// Concurrent checks on the converter sequencer ports
`timescale 1ns/1ps
module adcseq_chk
   import adcseq_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Observed ports
   input wire adcseq_bus_t i_bus,
   input wire logic [7:0] o_rdata,
   input wire logic i_sleep,
   input wire logic o_wake,
   input wire logic o_conversion_done_flag,
   input wire adcseq_analog_t o_analog
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);
   // ==========================================================
   // Conversion steps
   sequence s_conv_start;
      $fell(o_analog.sample) && o_analog.power;
   endsequence
   sequence s_conv_end;
      $rose(o_conversion_done_flag);
   endsequence
   // ==========================================================
   // Properties
   chk_gap_after_done: assert property (s_conv_end |-> !o_analog.sample [*3])
      else $error("hold capacitor reconnected too early");
   chk_trial_msb: assert property (s_conv_start |-> ##[0:8] o_analog.trial == 8'h80)
      else $error("conversion did not start at the top bit");
   chk_done_clear: assert property ($fell(o_conversion_done_flag) |->
      $past(i_bus.wr && i_bus.addr == REG_FLAGS))
      else $error("done flag cleared without a write");
   chk_sample_power: assert property (o_analog.sample |-> o_analog.power)
      else $error("acquiring while powered down");
   chk_wake_pulse: assert property (o_wake |=> !o_wake)
      else $error("wake longer than one cycle");
   chk_wake_sleep: assert property (o_wake |-> $past(i_sleep) ##1 o_conversion_done_flag)
      else $error("wake without sleep and completion");
   chk_done_powered: assert property (s_conv_end |-> $past(o_analog.power))
      else $error("completion while unpowered");
   chk_rdata_idle: assert property (!$past(i_bus.rd) |-> o_rdata == 8'h00)
      else $error("read data outside the answer cycle");
endmodule : adcseq_chk

// File: tb/tb_adcseq_top.sv
// Register-level testbench for the converter sequencer
`timescale 1ns/1ps
module tb_adcseq_top
   import adcseq_pkg::*;
;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic rc = 1'b0;
   logic sleep = 1'b0;
   logic trig = 1'b0;
   logic [3:0] mode = 4'h0;
   adcseq_bus_t bus = '0;
   logic [7:0] rdata;
   logic wake;
   logic done;
   logic comp;
   logic [4:0] pins;
   adcseq_analog_t analog;
   // Channel 0 runs at the two-period clock, so its full-scale level still reads back exactly
   logic [7:0] level [5] = '{8'hFF, 8'h3C, 8'h96, 8'h01, 8'hFE};
   int err_count = 0;
   int compares = 0;
   int n;

   always #50 clk = ~clk;
   // Free running RC source, deliberately unrelated to the system clock
   always #1700 rc = ~rc;

   adcseq_top i_dut (.i_clk(clk), .i_rst(rst), .i_bus(bus), .o_rdata(rdata),
      .i_sleep(sleep), .i_special_trigger(trig), .i_compare_mode_field(mode),
      .o_wake(wake), .o_conversion_done_flag(done), .i_rc_conversion_clock(rc),
      .i_comp_above(comp), .i_pin_level(pins), .o_analog(analog));
   adcseq_pins i_pins (.i_clk(clk), .i_analog(analog), .i_level(level),
      .o_comp_above(comp), .o_pin_level(pins));

   // ==========================================================
   // Tasks
   task automatic give_verdict();
      $display("compares=%0d err_count=%0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t seen=%h expected=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      bus.addr <= a;
      bus.wdata <= d;
      bus.wr <= 1'b1;
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask : wr
   task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk);
      bus.addr <= a;
      bus.rd <= 1'b1;
      @(posedge clk);
      bus.rd <= 1'b0;
      #1 chk({8'h00, rdata}, {8'h00, e});
   endtask : rdchk
   // Polls done flag (0), sample (1) or wake (2); a bound that runs out ends the run
   task automatic wait_sig(input int sel, input int lim, output int cnt);
      logic hit;
      cnt = 0;
      do begin
         @(posedge clk);
         #1 cnt++;
         hit = (sel == 0) ? done : (sel == 1) ? analog.sample : wake;
      end while (hit !== 1'b1 && cnt < lim);
      if (hit !== 1'b1) begin
         err_count++;
         give_verdict();
      end
   endtask : wait_sig
   task automatic trig_chk(input logic [3:0] m, input logic [7:0] e);
      @(posedge clk);
      mode <= m;
      trig <= 1'b1;
      @(posedge clk);
      trig <= 1'b0;
      repeat (40) @(posedge clk);
      rdchk(REG_FLAGS, e);
   endtask : trig_chk
   function automatic logic [7:0] ctrl(input logic [1:0] cs, input logic [2:0] ch,
      input logic go);
      return {cs, ch, go, 1'b0, 1'b1};
   endfunction : ctrl

   // ==========================================================
   // Main sequence
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      rdchk(REG_CTRL, CTRL_RESET);
      rdchk(REG_FLAGS, 8'h00);
      rdchk(4'hF, 8'h00);
      wr(REG_RESULT, 8'h5A);
      rdchk(REG_RESULT, 8'h5A);
      wr(REG_ANCFG, 8'h00);
      rdchk(REG_PORT, 8'h00);
      wr(REG_ANCFG, 8'h07);
      rdchk(REG_PORT, 8'h15);
      for (int i = 0; i < 3; i++) begin
         wr(REG_CTRL, ctrl(2'(i), 3'(i), 1'b0));
         wait_sig(1, 400, n);
         wr(REG_CTRL, ctrl(2'(i), 3'(i), 1'b1));
         wait_sig(0, 400, n);
         chk({15'h0, n >= 19 << (2 * i) && n <= (19 << (2 * i)) + 6}, 16'h1);
         rdchk(REG_RESULT, level[i]);
         rdchk(REG_CTRL, ctrl(2'(i), 3'(i), 1'b0));
         rdchk(REG_FLAGS, 8'h01);
         wr(REG_FLAGS, 8'h00);
      end
      wait_sig(1, 200, n);
      wr(REG_CTRL, ctrl(CLK_DIV8, 3'h0, 1'b1));
      repeat (20) @(posedge clk);
      wr(REG_CTRL, ctrl(CLK_DIV8, 3'h0, 1'b0));
      wait_sig(1, 40, n);
      chk({15'h0, n >= 16 && n <= 18}, 16'h1);
      rdchk(REG_RESULT, level[2]);
      rdchk(REG_FLAGS, 8'h00);
      wr(REG_CTRL, 8'h00);
      trig_chk(CMP_MODE_TRIGGER, 8'h00);
      wr(REG_CTRL, ctrl(CLK_DIV2, 3'h3, 1'b0));
      wait_sig(1, 20, n);
      trig_chk(4'h0, 8'h00);
      trig_chk(CMP_MODE_TRIGGER, 8'h01);
      rdchk(REG_RESULT, level[3]);
      wr(REG_FLAGS, 8'h00);
      wait_sig(1, 40, n);
      wr(REG_CTRL, ctrl(CLK_DIV32, 3'h2, 1'b1));
      // Six bit periods leave the top four bits settled before the fast clock
      repeat (190) @(posedge clk);
      wr(REG_CTRL, ctrl(CLK_DIV2, 3'h2, 1'b1));
      wait_sig(0, 80, n);
      chk({15'h0, n >= 7 && n <= 9}, 16'h1);
      @(posedge clk);
      bus.addr <= REG_RESULT;
      bus.rd <= 1'b1;
      @(posedge clk);
      bus.rd <= 1'b0;
      #1 chk({8'h00, rdata & 8'hF0}, {8'h00, level[2] & 8'hF0});
      wr(REG_FLAGS, 8'h00);
      wait_sig(1, 40, n);
      wr(REG_CTRL, ctrl(CLK_DIV32, 3'h4, 1'b1));
      repeat (30) @(posedge clk);
      sleep <= 1'b1;
      repeat (3) @(posedge clk);
      #1 chk({15'h0, analog.power}, 16'h0);
      repeat (400) @(posedge clk);
      sleep <= 1'b0;
      rdchk(REG_FLAGS, 8'h00);
      wr(REG_FLAGS, 8'h02);
      wr(REG_CTRL, ctrl(CLK_RC, 3'h1, 1'b0));
      wait_sig(1, 400, n);
      wr(REG_CTRL, ctrl(CLK_RC, 3'h1, 1'b1));
      sleep <= 1'b1;
      @(posedge clk);
      #1 chk({15'h0, analog.sample}, 16'h1);
      wait_sig(2, 800, n);
      @(posedge clk);
      sleep <= 1'b0;
      rdchk(REG_RESULT, level[1]);
      rdchk(REG_FLAGS, 8'h03);
      give_verdict();
   end
endmodule : tb_adcseq_top

bind adcseq_top adcseq_chk i_chk (.i_clk(i_clk), .i_rst(i_rst), .i_bus(i_bus),
   .o_rdata(o_rdata), .i_sleep(i_sleep), .o_wake(o_wake),
   .o_conversion_done_flag(o_conversion_done_flag), .o_analog(o_analog));
